// [core/rgb_light_sensor_readout.sv]
// Colour sensor readout: configuration, integration timing, results and window alarm
`default_nettype none

// How it works
// - Resolution selectable 12 or 16 bits
// - Narrow resolution gives proportionally shorter conversion
// - Wide mode integrates about 100 ms
// - Oscillator ticks drive n-bit window counter
// - Two sensitivity ranges, fine and coarse
// - Sync bit set releases the alarm pin
// - Sync mode starts conversion on pin rise
// - Sync bit clear drives pin on alarm
// - Alarm pin active low, open drain
// - Conversions continue; results keep overwriting
// - Persistence count gates out-of-window alarms
// - Bits 1:0 at 0x03 pick channel
// - Alarm when count leaves threshold window
// - Green 0x9/0xA, red 0xB/0xC, blue 0xD/0xE
// - Alarm sets status bit, pulls pin low
// - Reading status register clears flag and pin
// - Status flag reads zero after reset
// - Standby after reset release, reset when asserted
// - Register access blocked during power-on reset
module rgb_light_sensor_readout #(
	parameter int unsigned tick_cycles  = rgb_sensor_pkg::TICK_CYCLES,
	parameter int unsigned range_divide = rgb_sensor_pkg::RANGE_DIVIDE,
	parameter logic [7:0]  device_id    = 8'hA5 // Arbitrary value
) (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire rgb_sensor_pkg::reg_req_type reg_req,
	output logic                       [7:0] reg_rdata,
	input  wire logic                  [2:0] light_pulse,
	input  wire logic                        int_in,
	output logic                             int_out,
	output logic                             int_oe
);

	localparam int TW = (tick_cycles > 1) ? $clog2(tick_cycles) : 1;

	if (tick_cycles < 1)
	begin : g_bad_tick
		$error("tick_cycles must be at least 1");
	end

	// ==========================================================
	// Pin synchronisers
	logic       pin_s1;
	logic       pin_s2;
	logic       pin_prev;
	logic [2:0] light_s1;
	logic [2:0] light_s2;
	logic [2:0] light_prev;
	logic       pin_rise;
	logic [2:0] light_rise;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			pin_prev <= 1'b1;
			light_s1 <= 3'h0;
			light_s2 <= 3'h0;
			light_prev <= 3'h0;
		end
		else
		begin
			pin_s1 <= int_in;
			pin_s2 <= pin_s1;
			pin_prev <= pin_s2;
			light_s1 <= light_pulse;
			light_s2 <= light_s1;
			light_prev <= light_s2;
		end
	end

	assign pin_rise = pin_s2 & ~pin_prev;
	assign light_rise = light_s2 & ~light_prev;

	// ==========================================================
	// Registers and flags
	logic [7:0]  config_one;
	logic [7:0]  interrupt_config;
	logic [15:0] thresh_low;
	logic [15:0] thresh_high;
	logic [15:0] green_count;
	logic [15:0] red_count;
	logic [15:0] blue_count;
	logic        window_alarm_flag;
	logic        done_flag;
	logic [3:0]  persist_cnt;
	logic [7:0]  next_config_one;
	logic [7:0]  next_interrupt_config;
	logic [15:0] next_thresh_low;
	logic [15:0] next_thresh_high;
	logic [15:0] next_green_count;
	logic [15:0] next_red_count;
	logic [15:0] next_blue_count;
	logic        next_window_alarm_flag;
	logic        next_done_flag;
	logic [3:0]  next_persist_cnt;
	logic [7:0]  next_reg_rdata;
	logic        next_int_oe;
	logic [15:0] ch_count [3];
	logic [15:0] sel_count;
	logic [3:0]  persist_need;
	logic        out_window;
	logic        set_event;
	logic        status_read;
	logic        conv_start;
	logic        conv_end;

	wire logic       sync_mode   = config_one[rgb_sensor_pkg::CFG_SYNC_BIT];
	wire logic       wide        = ~config_one[rgb_sensor_pkg::CFG_RES_BIT];
	wire logic       sensitivity_select = config_one[rgb_sensor_pkg::CFG_RANGE_BIT];
	wire logic [2:0] mode = config_one[rgb_sensor_pkg::CFG_MODE_LSB +: rgb_sensor_pkg::CFG_MODE_W];
	wire logic [1:0] int_sel = interrupt_config[rgb_sensor_pkg::INT_SEL_LSB +: 2];
	wire logic [1:0] persist_code = interrupt_config[rgb_sensor_pkg::INT_PERSIST_LSB +: 2];

	always_comb
	begin
		next_config_one = config_one;
		next_interrupt_config = interrupt_config;
		next_thresh_low = thresh_low;
		next_thresh_high = thresh_high;
		next_green_count = green_count;
		next_red_count = red_count;
		next_blue_count = blue_count;
		// Writes only land after reset release: reset holds every register
		if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				rgb_sensor_pkg::ADDR_CONFIG_ONE: next_config_one = reg_req.wdata;
				rgb_sensor_pkg::ADDR_INT_CONFIG: next_interrupt_config = reg_req.wdata;
				rgb_sensor_pkg::ADDR_LOW_LO:     next_thresh_low[7:0] = reg_req.wdata;
				rgb_sensor_pkg::ADDR_LOW_HI:     next_thresh_low[15:8] = reg_req.wdata;
				rgb_sensor_pkg::ADDR_HIGH_LO:    next_thresh_high[7:0] = reg_req.wdata;
				rgb_sensor_pkg::ADDR_HIGH_HI:    next_thresh_high[15:8] = reg_req.wdata;
				default: ;
			endcase
		end
		// Results are overwritten every conversion, alarm or not
		if (conv_end)
		begin
			next_green_count = ch_count[0];
			next_red_count = ch_count[1];
			next_blue_count = ch_count[2];
		end
		unique case (int_sel)
			rgb_sensor_pkg::SEL_GREEN: sel_count = ch_count[0];
			rgb_sensor_pkg::SEL_RED:   sel_count = ch_count[1];
			rgb_sensor_pkg::SEL_BLUE:  sel_count = ch_count[2];
			default:                   sel_count = 16'h0000;
		endcase
		out_window = (int_sel != rgb_sensor_pkg::SEL_NONE)
			&& (sel_count < thresh_low || sel_count > thresh_high);
		persist_need = 4'(1 << persist_code);
		next_persist_cnt = persist_cnt;
		set_event = 1'b0;
		if (conv_end)
		begin
			if (out_window)
			begin
				set_event = (persist_cnt + 4'h1) >= persist_need;
				if (persist_cnt < persist_need)
					next_persist_cnt = persist_cnt + 4'h1;
			end
			else
				next_persist_cnt = 4'h0;
		end
		status_read = reg_req.rd_done && reg_req.addr == rgb_sensor_pkg::ADDR_STATUS;
		// A new alarm in the clearing cycle survives the read
		next_window_alarm_flag = set_event | (window_alarm_flag & ~status_read);
		next_done_flag = conv_end | (done_flag & ~status_read);
		next_int_oe = next_window_alarm_flag
			& ~next_config_one[rgb_sensor_pkg::CFG_SYNC_BIT];
		unique case (reg_req.addr)
			rgb_sensor_pkg::ADDR_DEVICE_ID:  next_reg_rdata = device_id;
			rgb_sensor_pkg::ADDR_CONFIG_ONE: next_reg_rdata = config_one;
			rgb_sensor_pkg::ADDR_INT_CONFIG: next_reg_rdata = interrupt_config;
			rgb_sensor_pkg::ADDR_LOW_LO:     next_reg_rdata = thresh_low[7:0];
			rgb_sensor_pkg::ADDR_LOW_HI:     next_reg_rdata = thresh_low[15:8];
			rgb_sensor_pkg::ADDR_HIGH_LO:    next_reg_rdata = thresh_high[7:0];
			rgb_sensor_pkg::ADDR_HIGH_HI:    next_reg_rdata = thresh_high[15:8];
			rgb_sensor_pkg::ADDR_STATUS:     next_reg_rdata = {6'h00, done_flag, window_alarm_flag};
			rgb_sensor_pkg::ADDR_GREEN_LO:   next_reg_rdata = green_count[7:0];
			rgb_sensor_pkg::ADDR_GREEN_HI:   next_reg_rdata = green_count[15:8];
			rgb_sensor_pkg::ADDR_RED_LO:     next_reg_rdata = red_count[7:0];
			rgb_sensor_pkg::ADDR_RED_HI:     next_reg_rdata = red_count[15:8];
			rgb_sensor_pkg::ADDR_BLUE_LO:    next_reg_rdata = blue_count[7:0];
			rgb_sensor_pkg::ADDR_BLUE_HI:    next_reg_rdata = blue_count[15:8];
			default:                         next_reg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			config_one <= rgb_sensor_pkg::CONFIG_ONE_RESET;
			interrupt_config <= rgb_sensor_pkg::INT_CONFIG_RESET;
			thresh_low <= rgb_sensor_pkg::THRESH_LOW_RESET;
			thresh_high <= rgb_sensor_pkg::THRESH_HIGH_RESET;
			green_count <= 16'h0000;
			red_count <= 16'h0000;
			blue_count <= 16'h0000;
			window_alarm_flag <= 1'b0;
			done_flag <= 1'b0;
			persist_cnt <= 4'h0;
			reg_rdata <= 8'h00;
			int_oe <= 1'b0;
		end
		else
		begin
			config_one <= next_config_one;
			interrupt_config <= next_interrupt_config;
			thresh_low <= next_thresh_low;
			thresh_high <= next_thresh_high;
			green_count <= next_green_count;
			red_count <= next_red_count;
			blue_count <= next_blue_count;
			window_alarm_flag <= next_window_alarm_flag;
			done_flag <= next_done_flag;
			persist_cnt <= next_persist_cnt;
			reg_rdata <= next_reg_rdata;
			int_oe <= next_int_oe;
		end
	end

	// Pin is only ever pulled low, never driven high
	assign int_out = 1'b0;

	// ==========================================================
	// Conversion sequencer
	rgb_sensor_pkg::state_type state;
	rgb_sensor_pkg::state_type next_state;
	logic [TW-1:0] tick_cnt;
	logic [TW-1:0] next_tick_cnt;
	logic [15:0]   win_cnt;
	logic [15:0]   next_win_cnt;
	logic [15:0]   win_limit;
	logic          tick;

	always_comb
	begin
		next_state = state;
		next_tick_cnt = tick_cnt;
		next_win_cnt = win_cnt;
		conv_start = 1'b0;
		conv_end = 1'b0;
		tick = tick_cnt == TW'(tick_cycles - 1);
		// Narrow mode counts 2^12 ticks, one sixteenth of the wide window
		win_limit = wide ? rgb_sensor_pkg::COUNT_MAX_WIDE
			: rgb_sensor_pkg::COUNT_MAX_NARROW;
		unique case (state)
			rgb_sensor_pkg::ST_STANDBY:
			begin
				if (mode != 3'h0)
				begin
					if (sync_mode)
						next_state = rgb_sensor_pkg::ST_WAIT_SYNC;
					else
					begin
						next_state = rgb_sensor_pkg::ST_INTEGRATE;
						conv_start = 1'b1;
					end
				end
			end
			rgb_sensor_pkg::ST_WAIT_SYNC:
			begin
				if (mode == 3'h0)
					next_state = rgb_sensor_pkg::ST_STANDBY;
				else if (!sync_mode || pin_rise)
				begin
					next_state = rgb_sensor_pkg::ST_INTEGRATE;
					conv_start = 1'b1;
				end
			end
			rgb_sensor_pkg::ST_INTEGRATE:
			begin
				if (mode == 3'h0)
					next_state = rgb_sensor_pkg::ST_STANDBY;
				else if (tick)
				begin
					next_tick_cnt = '0;
					next_win_cnt = win_cnt + 16'h0001;
					if (win_cnt >= win_limit)
					begin
						conv_end = 1'b1;
						next_win_cnt = 16'h0000;
						// Free-running mode restarts at once
						if (sync_mode)
							next_state = rgb_sensor_pkg::ST_WAIT_SYNC;
						else
							conv_start = 1'b1;
					end
				end
				else
					next_tick_cnt = tick_cnt + 1'b1;
			end
			default: next_state = rgb_sensor_pkg::ST_STANDBY;
		endcase
		if (conv_start)
		begin
			next_tick_cnt = '0;
			next_win_cnt = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= rgb_sensor_pkg::ST_STANDBY;
			tick_cnt <= '0;
			win_cnt <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			win_cnt <= next_win_cnt;
		end
	end

	// ==========================================================
	// Channels: index 0 green, 1 red, 2 blue
	for (genvar c = 0; c < 3; c++)
	begin : g_channel
		channel_integrator #(
			.range_divide (range_divide)
		) u_channel (
			.ref_clk (ref_clk),
			.nrst    (nrst),
			.start   (conv_start),
			.run     (state == rgb_sensor_pkg::ST_INTEGRATE),
			.pulse   (light_rise[c]),
			.coarse  (sensitivity_select),
			.wide    (wide),
			.count   (ch_count[c])
		);
	end

	// ==========================================================
	// Checks
	logic after_reset;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			after_reset <= 1'b1;
		else
			after_reset <= 1'b0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence seq_sync_wait;
		state == rgb_sensor_pkg::ST_WAIT_SYNC && sync_mode && mode != 3'h0;
	endsequence
	sequence seq_sync_edge;
		seq_sync_wait ##0 pin_rise;
	endsequence

	chk_reset_standby: assert property (after_reset
		|-> state == rgb_sensor_pkg::ST_STANDBY && !window_alarm_flag && !int_oe)
		else $error("not in standby with clear flag after reset");
	chk_sync_start: assert property (seq_sync_edge
		|=> state == rgb_sensor_pkg::ST_INTEGRATE && win_cnt == 16'h0000)
		else $error("sync edge did not start conversion");
	chk_sync_release: assert property (sync_mode |-> !int_oe)
		else $error("pin driven in sync mode");
	chk_alarm_drives: assert property (window_alarm_flag && !sync_mode |-> int_oe)
		else $error("alarm not on pin");
	chk_status_clear: assert property (status_read && !set_event
		|=> !window_alarm_flag && !int_oe)
		else $error("status read did not clear alarm");
	chk_window_bound: assert property (!wide && $stable(wide)
		&& $past(win_cnt) <= rgb_sensor_pkg::COUNT_MAX_NARROW
		|-> win_cnt <= rgb_sensor_pkg::COUNT_MAX_NARROW)
		else $error("window counter past resolution");
	chk_results_latch: assert property ($changed(green_count)
		|| $changed(red_count) || $changed(blue_count) |-> $past(conv_end))
		else $error("result changed outside conversion end");
	chk_alarm_cause: assert property ($rose(window_alarm_flag)
		|-> $past(conv_end) && $past(out_window)
		&& $past(persist_cnt) + 4'h1 >= $past(persist_need))
		else $error("alarm without persistent out-of-window result");
	chk_write_lands: assert property (reg_req.wr
		&& reg_req.addr == rgb_sensor_pkg::ADDR_HIGH_HI
		|=> thresh_high[15:8] == $past(reg_req.wdata))
		else $error("threshold write lost");

endmodule // rgb_light_sensor_readout

`default_nettype wire

// [core/rgb_sensor_pkg.sv]
// Shared register map, field layout, reset values, timing and types of the colour sensor readout
`default_nettype none

package rgb_sensor_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_DEVICE_ID  = 8'h00;
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'h01;
	localparam logic [7:0] ADDR_INT_CONFIG = 8'h03;
	localparam logic [7:0] ADDR_LOW_LO     = 8'h04;
	localparam logic [7:0] ADDR_LOW_HI     = 8'h05;
	localparam logic [7:0] ADDR_HIGH_LO    = 8'h06;
	localparam logic [7:0] ADDR_HIGH_HI    = 8'h07;
	localparam logic [7:0] ADDR_STATUS     = 8'h08;
	localparam logic [7:0] ADDR_GREEN_LO   = 8'h09;
	localparam logic [7:0] ADDR_GREEN_HI   = 8'h0A;
	localparam logic [7:0] ADDR_RED_LO     = 8'h0B;
	localparam logic [7:0] ADDR_RED_HI     = 8'h0C;
	localparam logic [7:0] ADDR_BLUE_LO    = 8'h0D;
	localparam logic [7:0] ADDR_BLUE_HI    = 8'h0E;

	// ==========================================================
	// Field positions
	localparam int CFG_MODE_LSB     = 0;
	localparam int CFG_MODE_W       = 3;
	localparam int CFG_RANGE_BIT    = 3;
	localparam int CFG_RES_BIT      = 4;
	localparam int CFG_SYNC_BIT     = 5;
	localparam int INT_SEL_LSB      = 0;
	localparam int INT_PERSIST_LSB  = 2;
	localparam int STATUS_ALARM_BIT = 0;
	localparam int STATUS_DONE_BIT  = 1;

	// ==========================================================
	// Reset values and encodings
	localparam logic [7:0]  CONFIG_ONE_RESET  = 8'h00;
	localparam logic [7:0]  INT_CONFIG_RESET  = 8'h00;
	localparam logic [15:0] THRESH_LOW_RESET  = 16'h0000;
	localparam logic [15:0] THRESH_HIGH_RESET = 16'hFFFF;
	localparam logic [1:0]  SEL_NONE          = 2'h0;
	localparam logic [1:0]  SEL_GREEN         = 2'h1;
	localparam logic [1:0]  SEL_RED           = 2'h2;
	localparam logic [1:0]  SEL_BLUE          = 2'h3;
	localparam logic [15:0] COUNT_MAX_WIDE    = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX_NARROW  = 16'h0FFF;
	localparam int          RES_WIDE_BITS     = 16;
	localparam int          RES_NARROW_BITS   = 12;

	// ==========================================================
	// Timing
	localparam int CLK_FREQ_KHZ  = 250000;
	localparam int INTEG_TIME_MS = 100;
	localparam int INTEG_CYCLES  = INTEG_TIME_MS * CLK_FREQ_KHZ;
	localparam int TICK_CYCLES   = INTEG_CYCLES / (2 ** RES_WIDE_BITS);
	localparam int RANGE_DIVIDE  = 32;

	// ==========================================================
	// Types
	typedef struct packed {
		logic       wr;
		logic       rd_done;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef enum logic [2:0] {
		ST_STANDBY   = 3'b001,
		ST_WAIT_SYNC = 3'b010,
		ST_INTEGRATE = 3'b100
	} state_type;

endpackage

`default_nettype wire

// [core/channel_integrator.sv]
// One colour channel: counts photo quanta during an integration window
`default_nettype none

module channel_integrator #(
	parameter int unsigned range_divide = rgb_sensor_pkg::RANGE_DIVIDE
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic        run,
	input  wire logic        pulse,
	input  wire logic        coarse,
	input  wire logic        wide,
	output logic      [15:0] count
);

	localparam int PW = $clog2(range_divide);

	// Prescaler wraps at its full width, so only powers of two divide exactly
	if (range_divide < 2 || (1 << PW) != range_divide)
	begin : g_bad_range
		$error("range_divide must be a power of two of at least 2");
	end

	logic [PW-1:0] prescale;
	logic [PW-1:0] next_prescale;
	logic [15:0]   next_count;
	logic [15:0]   limit;
	logic          step;

	// ==========================================================
	// Accumulator
	always_comb
	begin
		limit = wide ? rgb_sensor_pkg::COUNT_MAX_WIDE : rgb_sensor_pkg::COUNT_MAX_NARROW;
		next_prescale = prescale;
		next_count = count;
		step = 1'b0;
		if (start)
		begin
			next_prescale = '0;
			next_count = '0;
		end
		else if (run && pulse)
		begin
			// Low sensitivity keeps only one quantum in range_divide
			if (coarse)
			begin
				next_prescale = prescale + 1'b1;
				step = &prescale;
			end
			else
				step = 1'b1;
			// Saturate so a bright scene pins at full scale, never wraps
			if (step && count < limit)
				next_count = count + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prescale <= '0;
			count <= 16'h0000;
		end
		else
		begin
			prescale <= next_prescale;
			count <= next_count;
		end
	end

	// ==========================================================
	// Checks
	chk_start_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
		start |=> count == 16'h0000)
		else $error("count not cleared by start");
	chk_count_step: assert property (@(posedge ref_clk) disable iff (!nrst)
		(count != $past(count)) |-> (count == $past(count) + 16'h0001) || $past(start))
		else $error("count moved by more than one");

endmodule // channel_integrator

`default_nettype wire

// [testbench/host_port_model.sv]
// Host-side model: register requests and the external pull on the alarm pin
`default_nettype none

module host_port_model (
	input  wire logic                        ref_clk,
	input  wire logic                  [7:0] reg_rdata,
	output var  rgb_sensor_pkg::reg_req_type reg_req,
	output var  logic                        pin_pull
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		reg_req  = '0;
		pin_pull = 1'b0;
	end

	// ==========================================================
	// Byte transfers, changed on the falling edge, held over one rising edge
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk);
		reg_req.addr  = addr;
		reg_req.wdata = data;
		reg_req.wr    = 1'b1;
		@(negedge ref_clk);
		reg_req.wr    = 1'b0;
		// Stale data must not look like a held byte
		reg_req.wdata = ~data;
	endtask

	task automatic rd_reg(input logic [7:0] addr, input logic clear, output logic [7:0] data);
		@(negedge ref_clk);
		reg_req.addr = addr;
		@(negedge ref_clk);
		data = reg_rdata;
		reg_req.rd_done = clear;
		@(negedge ref_clk);
		reg_req.rd_done = 1'b0;
	endtask

	// ==========================================================
	// Sync edge: pull the pin low, then release it to the pull-up
	task automatic sync_pulse();
		@(negedge ref_clk);
		pin_pull = 1'b1;
		repeat (4) @(negedge ref_clk);
		pin_pull = 1'b0;
	endtask
endmodule // host_port_model

`default_nettype wire

// [testbench/rgb_light_sensor_readout_tb.sv]
// Self-checking bench of the colour sensor readout against a register model
`default_nettype none

module rgb_light_sensor_readout_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned tick_cycles  = 1;
	localparam int unsigned range_divide = 4;
	localparam logic [7:0]  device_id    = 8'h3C; // Arbitrary value

	logic                        ref_clk;
	logic                        nrst;
	rgb_sensor_pkg::reg_req_type reg_req;
	logic                  [7:0] reg_rdata;
	logic                  [2:0] light_pulse;
	logic                        int_in;
	logic                        int_out;
	logic                        int_oe;
	logic                        pin_pull;
	logic                  [7:0] rd;
	logic                 [15:0] v16;
	int                          fail_count;
	int                          n_checks;
	time                         t0;
	int                          cyc;
	int                          exp_reg [0:15];
	int                          n [0:2];

	// Open-drain wire with pull-up
	assign int_in = (int_oe || pin_pull) ? int_out : 1'b1;

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	rgb_light_sensor_readout #(
		.tick_cycles (tick_cycles),
		.range_divide(range_divide),
		.device_id   (device_id)
	) u_dut (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.reg_req    (reg_req),
		.reg_rdata  (reg_rdata),
		.light_pulse(light_pulse),
		.int_in     (int_in),
		.int_out    (int_out),
		.int_oe     (int_oe)
	);

	host_port_model u_host (
		.ref_clk  (ref_clk),
		.reg_rdata(reg_rdata),
		.reg_req  (reg_req),
		.pin_pull (pin_pull)
	);

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		n_checks++;
		if (seen !== want)
		begin
			fail_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Register model
	task automatic model_reset();
		foreach (exp_reg[i]) exp_reg[i] = 0;
		exp_reg[0] = device_id;
		exp_reg[6] = 8'hFF;
		exp_reg[7] = 8'hFF;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.wr_reg(a, d);
		if (a == 8'h01 || (a >= 8'h03 && a <= 8'h07))
			exp_reg[a] = d;
	endtask

	task automatic rd_check(input logic [7:0] a);
		u_host.rd_reg(a, 1'b0, rd);
		check(rd, exp_reg[a], "register");
	endtask

	// Polls until a conversion has ended; a missing end closes the run
	task automatic poll_done();
		for (int i = 0; i < 3000; i++)
		begin
			u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b0, rd);
			if (rd[1] === 1'b1)
				return;
		end
		fail_count++;
		$display("wrong value at %0t: no conversion end", $time);
		end_sim();
	endtask

	task automatic rd16(input logic [7:0] a);
		u_host.rd_reg(a, 1'b0, rd);
		v16[7:0] = rd;
		u_host.rd_reg(a + 8'h01, 1'b0, rd);
		v16[15:8] = rd;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		nrst        = 1'b0;
		light_pulse = 3'h0;
		fail_count  = 0;
		n_checks    = 0;
		void'($urandom(32'h97A71BA6));
		// A write while reset is low must be lost
		u_host.wr_reg(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h11);
		@(negedge ref_clk);
		nrst = 1'b1;
		model_reset();
		for (int a = 0; a < 16; a++)
			rd_check(a[7:0]);
		// Thresholds take random bytes; result and status bytes refuse writes
		for (int a = 4; a < 10; a++)
		begin
			wr(a[7:0], 8'($urandom));
			rd_check(a[7:0]);
		end
		// Two sync-started conversions, fine then coarse range
		wr(rgb_sensor_pkg::ADDR_INT_CONFIG, 8'h00);
		for (int p = 0; p < 2; p++)
		begin
			wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, p ? 8'h39 : 8'h31);
			foreach (n[c]) n[c] = $urandom_range(60, 20);
			u_host.sync_pulse();
			repeat (8) @(negedge ref_clk);
			for (int i = 0; i < 60; i++)
			begin
				light_pulse = {i < n[2], i < n[1], i < n[0]};
				@(negedge ref_clk);
				light_pulse = 3'h0;
				@(negedge ref_clk);
			end
			poll_done();
			check(int_oe, 1'b0, "pin driven in sync mode");
			for (int c = 0; c < 3; c++)
			begin
				rd16(8'h09 + 8'(2 * c));
				check(v16, 16'(p ? n[c] / range_divide : n[c]), "count");
			end
			u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		end
		// Free-running, dark green channel below the low threshold, two in a row
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h00);
		wr(8'h04, 8'h05);
		wr(8'h05, 8'h00);
		wr(rgb_sensor_pkg::ADDR_INT_CONFIG, 8'h05);
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h11);
		poll_done();
		check(rd, 8'h02, "status after one");
		t0 = $time;
		check(int_oe, 1'b0, "pin after one");
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		poll_done();
		check(rd, 8'h03, "status after two");
		// Polling every third cycle blurs each end by up to two cycles
		cyc = int'(($time - t0) / 4) - (1 << rgb_sensor_pkg::RES_NARROW_BITS) * tick_cycles;
		check(16'(cyc >= -2 && cyc <= 2), 16'h0001, "narrow conversion period");
		check(int_in, 1'b0, "pin level");
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		check(int_oe, 1'b0, "pin after read");
		rd_check(rgb_sensor_pkg::ADDR_STATUS);
		// The alarm returns next conversion; sync mode then releases the pin
		poll_done();
		check(int_oe, 1'b1, "pin again");
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h31);
		@(negedge ref_clk);
		check(int_oe, 1'b0, "pin with sync set");
		check(int_in, 1'b1, "released pin");
		// Inside the window no alarm is raised
		wr(8'h04, 8'h00);
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h11);
		poll_done();
		poll_done();
		check(rd, 8'h02, "status in window");
		// Only blue is lit past the high threshold: blue alarms, red does not
		wr(8'h06, 8'h0A);
		wr(8'h07, 8'h00);
		for (int s = 0; s < 2; s++)
		begin
			wr(rgb_sensor_pkg::ADDR_INT_CONFIG, s ? 8'h02 : 8'h03);
			u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
			repeat (20)
			begin
				light_pulse = 3'h4;
				@(negedge ref_clk);
				light_pulse = 3'h0;
				@(negedge ref_clk);
			end
			poll_done();
			check(rd, s ? 8'h02 : 8'h03, "status by channel");
		end
		// A wide conversion is still running when a narrow one would be over
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h00);
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b1, rd);
		wr(rgb_sensor_pkg::ADDR_CONFIG_ONE, 8'h01);
		repeat ((1 << rgb_sensor_pkg::RES_NARROW_BITS) * tick_cycles + 100) @(negedge ref_clk);
		u_host.rd_reg(rgb_sensor_pkg::ADDR_STATUS, 1'b0, rd);
		check(rd, 8'h00, "wide conversion end");
		// Reset in mid-run restores the registers at 0x01 to 0x08
		@(negedge ref_clk);
		nrst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(reg_rdata, 8'h00, "read data in reset");
		nrst = 1'b1;
		model_reset();
		for (int a = 1; a < 9; a++)
			rd_check(a[7:0]);
		check(int_oe, 1'b0, "pin after reset");
		end_sim();
	end
endmodule // rgb_light_sensor_readout_tb

`default_nettype wire
